// >>> rtl/touch_channel_processing.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "touch_channel_cfg.svh"

module touch_channel_processing #(
  parameter bit CAPACITIVE = 1'b0,
  parameter int WD_CYCLES = `WD_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // sensing front end
  input wire logic [15:0] count_live,
  input wire logic count_done,
  output logic conv_stop,
  output logic [9:0] compensation,
  output logic [13:0] xfer_freq_khz,
  output logic tx_osc_sel,
  // pins
  input wire logic sample_sel_pin,
  input wire logic hard_clear_n,
  output logic touch_out_n,
  output logic sample_fast,
  output logic ultra_low_power,
  // i2c transaction events from the host port
  input wire logic i2c_start,
  input wire logic i2c_access,
  input wire logic i2c_stop,
  input wire logic i2c_end_cmd,
  output logic soft_reset
);

  touch_channel_pkg::state_t st_ff;
  touch_channel_pkg::state_t nxt_st;

  function automatic touch_channel_pkg::state_t init_state();
    touch_channel_pkg::state_t s;
    s = '0;
    s.ctrl = `CTRL_RESET;
    s.thresh = `THRESH_RESET;
    s.tune = `TUNE_RESET;
    s.timeout = `TIMEOUT_RESET;
    s.comp = `COMP_RESET;
    s.pmode = touch_channel_pkg::PM_NORMAL;
    s.touch_out_n = 1'b1;
    return s;
  endfunction : init_state

  // f + (x - f) * beta / 256
  function automatic logic [15:0] iir(input logic [15:0] f, input logic [15:0] x,
                                      input logic [7:0] beta);
    logic signed [17:0] d;
    logic signed [26:0] p;
    logic signed [18:0] s;
    d = $signed({2'b00, x}) - $signed({2'b00, f});
    p = d * $signed({1'b0, beta});
    s = $signed({3'b000, f}) + $signed(p[26:`BETA_SHIFT]);
    return s[15:0];
  endfunction : iir

  // target +/- target/8
  function automatic logic in_band(input logic [15:0] v, input logic [15:0] tgt);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = {1'b0, tgt} - {4'b0000, tgt[15:`BAND_SHIFT]};
    hi = {1'b0, tgt} + {4'b0000, tgt[15:`BAND_SHIFT]};
    return ({1'b0, v} >= lo) && ({1'b0, v} <= hi);
  endfunction : in_band

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [15:0] max_counts;
  logic [15:0] target;
  logic [15:0] sample;
  logic [15:0] cnt_new;
  logic [15:0] lta_new;
  logic [16:0] delta_pos;
  logic [16:0] delta_neg;
  logic [16:0] delta;
  logic negative;
  logic [7:0] t_val;
  logic [7:0] t_hyst;
  logic [8:0] rel_val;
  logic [23:0] touch_thr;
  logic [23:0] release_thr;
  logic interacting;
  logic do_reseed;
  logic [7:0] beta_c;
  logic [7:0] beta_l;
  logic [31:0] status;
  logic wr_fire;
  logic rd_fire;

  assign max_counts = st_ff.tune[31:16];
  assign target = st_ff.tune[15:0];
  assign t_val = st_ff.thresh[`THR_TOUCH_LSB +: 8];
  assign t_hyst = st_ff.thresh[`THR_HYST_LSB +: 8];

  assign conv_stop = count_live > max_counts;
  assign sample = conv_stop ? max_counts : count_live;

  assign beta_c = st_ff.beta_fast ? `BETA_CNT_FAST : `BETA_CNT_SLOW;
  assign beta_l = st_ff.beta_fast ? `BETA_LTA_FAST : `BETA_LTA_SLOW;
  assign cnt_new = iir(st_ff.cnt_f, sample, beta_c);
  assign lta_new = iir(st_ff.long_term_reference, cnt_new, beta_l);

  // compare against freshly filtered counts
  assign delta_pos = {1'b0, st_ff.long_term_reference} - {1'b0, cnt_new};
  assign delta_neg = {1'b0, cnt_new} - {1'b0, st_ff.long_term_reference};
  assign negative = cnt_new > st_ff.long_term_reference;
  assign delta = negative ? (st_ff.ctrl[`CTRL_DUAL_DIR] ? delta_neg : 17'h0_0000) : delta_pos;
  assign touch_thr = ({16'h0000, t_val} * {8'h00, st_ff.long_term_reference}) >> `BETA_SHIFT;
  assign rel_val = {1'b0, t_val} - {1'b0, t_hyst};
  assign release_thr = rel_val[8] ? 24'h00_0000 :
                       ({8'h00, st_ff.long_term_reference} * {16'h0000, rel_val[7:0]}) >> `BETA_SHIFT;
  assign interacting = st_ff.prox || st_ff.touch;

  assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign rd_fire = arvalid && arready;

  always_comb begin
    status = 32'h0000_0000;
    status[`ST_PROX] = st_ff.prox;
    status[`ST_TOUCH] = st_ff.touch;
    status[`ST_DIR] = st_ff.dir;
    status[`ST_TUNE_ERR] = st_ff.tune_err;
    status[`ST_RETUNE] = st_ff.retune_flag;
    status[`ST_TUNING] = st_ff.tuning;
    status[`ST_ULP] = st_ff.pmode == touch_channel_pkg::PM_ULTRA_LOW;
    status[`ST_SAMPLE_FAST] = st_ff.beta_fast;
  end

  always_comb begin
    nxt_st = st_ff;
    do_reseed = 1'b0;
    nxt_st.soft_reset = 1'b0;

    // bus slave: address and data taken in either order
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `RESP_OKAY;
      unique case (araddr)
        `REG_CTRL: nxt_st.rdata = st_ff.ctrl;
        `REG_THRESH: nxt_st.rdata = st_ff.thresh;
        `REG_TUNE: nxt_st.rdata = st_ff.tune;
        `REG_STATUS: nxt_st.rdata = status;
        `REG_VALUES: nxt_st.rdata = {st_ff.long_term_reference, st_ff.cnt_f};
        `REG_TIMEOUT: nxt_st.rdata = st_ff.timeout;
        `REG_COMP: nxt_st.rdata = {22'h00_0000, st_ff.comp};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // strap followed every cycle until the first conversion after reset release
    if (!st_ff.started) begin
      nxt_st.beta_fast = sample_sel_pin;
    end

    // one conversion: filter, tune, compare
    if (count_done) begin
      nxt_st.started = 1'b1;
      nxt_st.retune_flag = 1'b0;
      if (st_ff.holdoff != 8'h00) begin
        nxt_st.holdoff = st_ff.holdoff - 8'h01;
      end
      if (st_ff.tuning) begin
        nxt_st.cnt_f = sample;
        if (in_band(sample, target) || st_ff.comp == `COMP_MIN || st_ff.comp == `COMP_MAX
            || st_ff.tune_steps == `TUNE_MAX_STEPS) begin
          nxt_st.tuning = 1'b0;
          nxt_st.tune_err = !in_band(sample, target) || st_ff.comp == `COMP_MIN
                            || st_ff.comp == `COMP_MAX;
          if (nxt_st.tune_err) begin
            nxt_st.holdoff = `TUNE_ERR_HOLDOFF;
          end
          nxt_st.long_term_reference = sample;
          nxt_st.prox = 1'b0;
          nxt_st.touch = 1'b0;
          nxt_st.deb_cnt = 4'h0;
        end else begin
          nxt_st.tune_steps = st_ff.tune_steps + 11'h001;
          nxt_st.comp = (sample < target) ? st_ff.comp + 10'h001 : st_ff.comp - 10'h001;
        end
      end else if (!st_ff.started || (!in_band(st_ff.long_term_reference, target) && st_ff.holdoff == 8'h00)) begin
        nxt_st.tuning = 1'b1;
        nxt_st.retune_flag = st_ff.started;
        nxt_st.tune_steps = 11'h000;
      end else begin
        nxt_st.cnt_f = cnt_new;
        if (!interacting) begin
          nxt_st.long_term_reference = lta_new;
        end
        // proximity with debounce
        if ((delta >= {9'h000, st_ff.thresh[`THR_PROX_LSB +: 8]}) != st_ff.prox) begin
          if (st_ff.deb_cnt >= st_ff.thresh[`THR_DEB_LSB +: 4]) begin
            nxt_st.prox = !st_ff.prox;
            nxt_st.deb_cnt = 4'h0;
          end else begin
            nxt_st.deb_cnt = st_ff.deb_cnt + 4'h1;
          end
        end else begin
          nxt_st.deb_cnt = 4'h0;
        end
        // touch with hysteresis
        if (!st_ff.touch && {7'h00, delta} >= touch_thr && touch_thr != 24'h00_0000) begin
          nxt_st.touch = 1'b1;
          nxt_st.dir = negative;
        end else if (st_ff.touch && {7'h00, delta} < release_thr) begin
          nxt_st.touch = 1'b0;
        end else if (st_ff.touch && release_thr == 24'h00_0000 && delta == 17'h0_0000) begin
          nxt_st.touch = 1'b0;
        end
        // automatic reseed after long interaction
        if (interacting && st_ff.timeout[31:16] != 16'h0000) begin
          nxt_st.act_cnt = st_ff.act_cnt + 16'h0001;
          if (st_ff.act_cnt >= st_ff.timeout[31:16]) begin
            do_reseed = 1'b1;
          end
        end else begin
          nxt_st.act_cnt = 16'h0000;
        end
        // power mode stepping
        if (interacting) begin
          nxt_st.idle_cnt = 16'h0000;
          nxt_st.pmode = touch_channel_pkg::PM_NORMAL;
        end else if (st_ff.idle_cnt >= st_ff.timeout[15:0]) begin
          if (st_ff.ctrl[`CTRL_STEP_EN]) begin
            nxt_st.pmode = touch_channel_pkg::PM_ULTRA_LOW;
          end
        end else begin
          nxt_st.idle_cnt = st_ff.idle_cnt + 16'h0001;
        end
        if (st_ff.ctrl[`CTRL_RESEED]) begin
          do_reseed = 1'b1;
          nxt_st.ctrl[`CTRL_RESEED] = 1'b0;
        end
        if (do_reseed) begin
          nxt_st.long_term_reference = cnt_new;
          nxt_st.prox = 1'b0;
          nxt_st.touch = 1'b0;
          nxt_st.deb_cnt = 4'h0;
          nxt_st.act_cnt = 16'h0000;
        end
      end
    end
    nxt_st.touch_out_n = !nxt_st.touch;

    // register write after both halves arrived; set of reseed wins over clear
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `RESP_OKAY;
      unique case (st_ff.awaddr)
        `REG_CTRL: nxt_st.ctrl = merge(nxt_st.ctrl, st_ff.wdata, st_ff.wstrb) | (nxt_st.ctrl
                                 & (32'h0000_0001 << `CTRL_RESEED));
        `REG_THRESH: nxt_st.thresh = merge(st_ff.thresh, st_ff.wdata, st_ff.wstrb);
        `REG_TUNE: nxt_st.tune = merge(st_ff.tune, st_ff.wdata, st_ff.wstrb);
        `REG_TIMEOUT: nxt_st.timeout = merge(st_ff.timeout, st_ff.wdata, st_ff.wstrb);
        `REG_STATUS, `REG_VALUES, `REG_COMP: nxt_st.bresp = `RESP_OKAY;
        default: nxt_st.bresp = `RESP_SLVERR;
      endcase
    end

    // watchdog: host accesses restart it inside a transaction
    if (i2c_start) begin
      nxt_st.in_txn = 1'b1;
    end
    if (i2c_stop || i2c_end_cmd) begin
      nxt_st.in_txn = 1'b0;
    end
    if (i2c_start || i2c_access || (!st_ff.in_txn && count_done)) begin
      nxt_st.wd_cnt = 24'h00_0000;
    end else begin
      nxt_st.wd_cnt = st_ff.wd_cnt + 24'h00_0001;
    end
    if ({8'h00, st_ff.wd_cnt} >= WD_CYCLES - 1) begin
      nxt_st = init_state();
      nxt_st.soft_reset = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !hard_clear_n) begin
      st_ff <= init_state();
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = !st_ff.aw_got && !st_ff.bvalid;
  assign wready = !st_ff.w_got && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign compensation = st_ff.comp;
  assign touch_out_n = st_ff.touch_out_n;
  assign sample_fast = st_ff.beta_fast;
  assign ultra_low_power = st_ff.pmode == touch_channel_pkg::PM_ULTRA_LOW;
  assign tx_osc_sel = st_ff.ctrl[`CTRL_OSC_TX];
  assign xfer_freq_khz = st_ff.ctrl[`CTRL_OSC_TX] ? `XFER_KHZ_OSC :
                         (CAPACITIVE ? `XFER_KHZ_CAPACITIVE : `XFER_KHZ_INDUCTIVE);
  assign soft_reset = st_ff.soft_reset;

endmodule : touch_channel_processing

// >>> rtl/touch_channel_cfg.svh
`ifndef TOUCH_CHANNEL_CFG_SVH
`define TOUCH_CHANNEL_CFG_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_THRESH 8'h04
`define REG_TUNE 8'h08
`define REG_STATUS 8'h0C
`define REG_VALUES 8'h10
`define REG_TIMEOUT 8'h14
`define REG_COMP 8'h18

// control fields
`define CTRL_RESEED 0
`define CTRL_OSC_TX 1
`define CTRL_DUAL_DIR 2
`define CTRL_STEP_EN 3
`define CTRL_RESET 32'h0000_0008

// threshold fields: prox delta, touch value, hysteresis, debounce
`define THR_PROX_LSB 0
`define THR_TOUCH_LSB 8
`define THR_HYST_LSB 16
`define THR_DEB_LSB 24
`define THRESH_RESET 32'h0310_4010

// tuning target (low half) and maximum counts (high half)
`define TUNE_RESET 32'hFFFF_0320

// power-step timeout (low half) and interaction reseed timeout (high half), conversions
`define TIMEOUT_RESET 32'h0064_0064

// status fields
`define ST_PROX 0
`define ST_TOUCH 1
`define ST_DIR 2
`define ST_TUNE_ERR 3
`define ST_RETUNE 4
`define ST_TUNING 5
`define ST_ULP 6
`define ST_SAMPLE_FAST 7

// tuning limits
`define COMP_MIN 10'h000
`define COMP_MAX 10'h3FF
`define COMP_RESET 10'h200
`define TUNE_MAX_STEPS 11'h400
`define TUNE_ERR_HOLDOFF 8'h40
`define BAND_SHIFT 3

// filter betas, damping = beta / 256
`define BETA_CNT_SLOW 8'h80
`define BETA_LTA_SLOW 8'h04
`define BETA_CNT_FAST 8'h40
`define BETA_LTA_FAST 8'h02
`define BETA_SHIFT 8

// transfer frequencies in kHz
`define XFER_KHZ_INDUCTIVE 14'h36B0
`define XFER_KHZ_CAPACITIVE 14'h03E8
`define XFER_KHZ_OSC 14'h3E80

// watchdog
`define CLK_HZ 50000000
`define WD_TIMEOUT_MS 255
`define WD_CYCLES (`WD_TIMEOUT_MS * (`CLK_HZ / 1000))

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> rtl/touch_channel_pkg.sv
package touch_channel_pkg;

  typedef enum logic {PM_NORMAL, PM_ULTRA_LOW} power_mode_t;

  typedef struct packed {
    // bus slave
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    // software registers
    logic [31:0] ctrl;
    logic [31:0] thresh;
    logic [31:0] tune;
    logic [31:0] timeout;
    // channel processing
    logic started;
    logic beta_fast;
    logic [15:0] cnt_f;
    logic [15:0] long_term_reference;
    logic [9:0] comp;
    logic tuning;
    logic [10:0] tune_steps;
    logic tune_err;
    logic retune_flag;
    logic [7:0] holdoff;
    logic prox;
    logic [3:0] deb_cnt;
    logic touch;
    logic dir;
    logic [15:0] idle_cnt;
    logic [15:0] act_cnt;
    power_mode_t pmode;
    logic touch_out_n;
    // watchdog
    logic in_txn;
    logic [23:0] wd_cnt;
    logic soft_reset;
  } state_t;

endpackage : touch_channel_pkg

// >>> dv/touch_channel_sva.sv
`timescale 1ns/1ns
module touch_channel_sva #(
  parameter int WD_CYCLES = 200
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // channel
  input wire logic count_done,
  input wire logic [9:0] compensation,
  input wire logic hard_clear_n,
  input wire logic touch_out_n,
  input wire logic ultra_low_power,
  // host events
  input wire logic i2c_start,
  input wire logic i2c_access,
  input wire logic i2c_stop,
  input wire logic i2c_end_cmd,
  input wire logic soft_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic in_txn_ff;
  int wd_ff;
  // cycles since the last watchdog restart
  always_ff @(posedge aclk) begin
    if (!aresetn || !hard_clear_n || soft_reset) begin
      in_txn_ff <= 1'b0;
      wd_ff <= 0;
    end else begin
      in_txn_ff <= (in_txn_ff || i2c_start) && !(i2c_stop || i2c_end_cmd);
      wd_ff <= (i2c_start || i2c_access || (count_done && !in_txn_ff)) ? 0 : wd_ff + 1;
    end
  end

  reset_out_a: assert property (!hard_clear_n |=> touch_out_n && !bvalid && !rvalid
    && !soft_reset && compensation == 10'h200 && !ultra_low_power)
    else $error("clear did not restore outputs");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  read_ans_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  write_ans_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  wd_expire_a: assert property (soft_reset |-> wd_ff >= WD_CYCLES - 2
    && wd_ff <= WD_CYCLES + 3)
    else $error("soft reset at wrong time");
  wd_late_a: assert property (wd_ff <= WD_CYCLES + 3)
    else $error("watchdog did not expire");
  touch_cause_a: assert property ($changed(touch_out_n) |-> $past(count_done)
    || !$past(hard_clear_n) || soft_reset || $past(soft_reset))
    else $error("touch output moved without conversion");
  comp_cause_a: assert property ($changed(compensation) |-> $past(count_done)
    || !$past(hard_clear_n) || soft_reset || $past(soft_reset))
    else $error("compensation moved without conversion");
  ulp_cause_a: assert property ($rose(ultra_low_power) |-> $past(count_done))
    else $error("power step without conversion");
endmodule : touch_channel_sva

// >>> dv/front_end_model.sv
`timescale 1ns/1ns
module front_end_model #(
  parameter int PERIOD = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench control
  input wire logic run,
  input wire logic [15:0] level,
  // sensing interface
  input wire logic conv_stop,
  output logic [15:0] count_live,
  output logic count_done
);
  int phase_ff;
  always_ff @(posedge aclk) begin
    count_live <= level;
    if (!aresetn || !run) begin
      phase_ff <= 0;
      count_done <= 1'b0;
    end else if (phase_ff == PERIOD - 1 || (conv_stop && phase_ff > 0)) begin
      phase_ff <= 0;
      count_done <= 1'b1;
    end else begin
      phase_ff <= phase_ff + 1;
      count_done <= 1'b0;
    end
  end
endmodule : front_end_model

// >>> dv/touch_channel_processing_tb.sv
`timescale 1ns/1ns
`include "touch_channel_cfg.svh"
module touch_channel_processing_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] i2c_ev = 4'h0;
  logic run = 1'b0, sample_sel_pin = 1'b0, hard_clear_n = 1'b1;
  logic [15:0] level = 16'h0320;
  logic awready, wready, bvalid, arready, rvalid, conv_stop, tx_osc_sel, touch_out_n;
  logic sample_fast, ultra_low_power, soft_reset, count_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [15:0] count_live, lr;
  logic [9:0] compensation, c;
  logic [13:0] xfer_freq_khz;
  logic [7:0] ra [5] = '{`REG_CTRL, `REG_THRESH, `REG_TUNE, `REG_TIMEOUT, `REG_COMP};
  logic [31:0] rv [5] = '{`CTRL_RESET, `THRESH_RESET, `TUNE_RESET, `TIMEOUT_RESET, 32'h0000_0200};
  int fail_count = 0;
  int compares = 0;
  int sr_cnt = 0;

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (soft_reset === 1'b1) sr_cnt++;

  touch_channel_processing #(.WD_CYCLES(200)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .count_live,
    .count_done, .conv_stop, .compensation, .xfer_freq_khz, .tx_osc_sel, .sample_sel_pin,
    .hard_clear_n, .touch_out_n, .sample_fast, .ultra_low_power, .i2c_start(i2c_ev[3]),
    .i2c_access(i2c_ev[2]), .i2c_stop(i2c_ev[1]), .i2c_end_cmd(i2c_ev[0]), .soft_reset);
  front_end_model u_fe (.aclk, .aresetn, .run, .level, .conv_stop, .count_live, .count_done);

  task automatic end_sim();
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] q);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    q = rdata;
    rready <= 1'b0;
    check(32'(rresp), 32'(er));
  endtask : rd

  // waits for n conversions, returns where outputs have settled
  task automatic conv(input int n);
    repeat (n) begin
      @(posedge aclk);
      while (count_done !== 1'b1) @(posedge aclk);
    end
    @(negedge aclk);
  endtask : conv

  task automatic fe(input logic r, input logic [15:0] v);
    @(posedge aclk);
    run <= r;
    level <= v;
  endtask : fe

  task automatic ev(input logic [3:0] k);
    @(posedge aclk);
    i2c_ev <= k;
    @(posedge aclk);
    i2c_ev <= 4'h0;
  endtask : ev

  task automatic st(input int b, input logic e);
    rd(`REG_STATUS, `RESP_OKAY, d);
    check(32'(d[b]), 32'(e));
  endtask : st

  task automatic ref_in(input logic [15:0] lo, input logic [15:0] hi);
    rd(`REG_VALUES, `RESP_OKAY, d);
    check(32'(d[31:16] >= lo && d[31:16] <= hi), 32'h1);
  endtask : ref_in

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], `RESP_OKAY, d);
      check(d, rv[i]);
    end
    check(32'(xfer_freq_khz), 32'(`XFER_KHZ_INDUCTIVE));
    check(32'(sample_fast), 32'h0);
    rd(8'h40, `RESP_SLVERR, d);
    check(d, 32'h0000_0000);
    wr(8'h44, 32'h1234_5678, 4'hF, `RESP_SLVERR);
    wr(`REG_COMP, 32'h0000_0001, 4'hF, `RESP_OKAY);
    rd(`REG_COMP, `RESP_OKAY, d);
    check(d, 32'h0000_0200);
    wr(`REG_THRESH, 32'hFFFF_FF20, 4'h1, `RESP_OKAY);
    rd(`REG_THRESH, `RESP_OKAY, d);
    check(d, 32'h0310_4020);
    wr(`REG_THRESH, `THRESH_RESET, 4'hF, `RESP_OKAY);
    wr(`REG_CTRL, 32'h0000_000A, 4'hF, `RESP_OKAY);
    @(negedge aclk);
    check(32'(tx_osc_sel), 32'h1);
    check(32'(xfer_freq_khz), 32'(`XFER_KHZ_OSC));
    wr(`REG_CTRL, `CTRL_RESET, 4'hF, `RESP_OKAY);
    wr(`REG_TUNE, 32'h03E8_0320, 4'hF, `RESP_OKAY);
    fe(1'b0, 16'h07D0);
    repeat (2) @(negedge aclk);
    check(32'(conv_stop), 32'h1);
    fe(1'b0, 16'h0320);
    repeat (2) @(negedge aclk);
    check(32'(conv_stop), 32'h0);
    wr(`REG_TUNE, `TUNE_RESET, 4'hF, `RESP_OKAY);
    // settle at the tuning target, then seed the reference from the host
    fe(1'b1, 16'h0320);
    conv(40);
    wr(`REG_CTRL, 32'h0000_0009, 4'hF, `RESP_OKAY);
    conv(120);
    st(`ST_ULP, 1'b1);
    check(32'(ultra_low_power), 32'h1);
    st(`ST_TUNE_ERR, 1'b0);
    ref_in(16'd790, 16'd810);
    fe(1'b1, 16'd625);
    conv(20);
    st(`ST_TOUCH, 1'b0);
    st(`ST_PROX, 1'b1);
    ref_in(16'd760, 16'd799);
    lr = d[31:16];
    fe(1'b1, 16'd500);
    conv(15);
    check(32'(touch_out_n), 32'h0);
    ref_in(lr, lr);
    fe(1'b1, 16'd625);
    conv(15);
    check(32'(touch_out_n), 32'h0);
    fe(1'b1, 16'd720);
    conv(15);
    check(32'(touch_out_n), 32'h1);
    // long interaction triggers the automatic reseed
    conv(60);
    ref_in(16'd700, 16'd740);
    st(`ST_PROX, 1'b0);
    wr(`REG_CTRL, 32'h0000_000C, 4'hF, `RESP_OKAY);
    fe(1'b1, 16'd1000);
    conv(15);
    check(32'(touch_out_n), 32'h0);
    st(`ST_DIR, 1'b1);
    wr(`REG_CTRL, 32'h0000_000D, 4'hF, `RESP_OKAY);
    conv(2);
    check(32'(touch_out_n), 32'h1);
    st(`ST_TUNING, 1'b1);
    // reference now outside the band and the count never answers
    d = 32'h0000_0000;
    for (int i = 0; i < 300 && d[`ST_TUNE_ERR] !== 1'b1; i++) begin
      conv(4);
      rd(`REG_STATUS, `RESP_OKAY, d);
    end
    check(32'(d[`ST_TUNE_ERR]), 32'h1);
    check(32'(compensation == `COMP_MIN || compensation == `COMP_MAX), 32'h1);
    c = compensation;
    conv(20);
    check(32'(compensation), 32'(c));
    st(`ST_TUNE_ERR, 1'b1);
    wr(`REG_TIMEOUT, 32'h0000_0001, 4'hF, `RESP_OKAY);
    @(posedge aclk);
    hard_clear_n <= 1'b0;
    @(posedge aclk);
    hard_clear_n <= 1'b1;
    @(negedge aclk);
    check(32'(compensation), 32'h0000_0200);
    check(32'(touch_out_n), 32'h1);
    rd(`REG_TIMEOUT, `RESP_OKAY, d);
    check(d, `TIMEOUT_RESET);
    ev(4'h8);
    repeat (3) begin
      repeat (150) @(posedge aclk);
      ev(4'h4);
    end
    repeat (150) @(posedge aclk);
    ev(4'h1);
    ev(4'h8);
    ev(4'h2);
    repeat (260) @(posedge aclk);
    check(32'(sr_cnt), 32'h0);
    wr(`REG_CTRL, 32'h0000_000A, 4'hF, `RESP_OKAY);
    ev(4'h8);
    repeat (260) @(posedge aclk);
    check(32'(sr_cnt), 32'h1);
    rd(`REG_CTRL, `RESP_OKAY, d);
    check(d, `CTRL_RESET);
    @(posedge aclk);
    aresetn <= 1'b0;
    sample_sel_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    check(32'(sample_fast), 32'h1);
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
endmodule : touch_channel_processing_tb

bind touch_channel_processing touch_channel_sva #(.WD_CYCLES(WD_CYCLES)) u_sva (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
  .rready, .rdata, .count_done, .compensation, .hard_clear_n, .touch_out_n, .ultra_low_power,
  .i2c_start, .i2c_access, .i2c_stop, .i2c_end_cmd, .soft_reset);
